// >>> hdl/tlc_core.sv
// lookup table code path, code select, output switches and APB registers
// assumes synchronous pins and a sensor sample strobe in the pclk domain
// How it works
// - table covers minus 28 to 128 degrees
// - below table, lowest increment extrapolates to -40
// - top entry interpolates above 124 degrees
// - increments are 4-bit unsigned values
// - table excursion stays within 624 codes
// - code is base plus accumulated increments
// - code is offset binary, 0x000 to 0xFFF
// - forced select swaps table code for forced code
// - forced code spans all 4096 codes
// - two identical channels
// - readable flag shows rail span below ground
// - output follows its enable pin only
// - both switches open before new one closes
// - output rests on negative rail after reset
// - byte registers act when transfer completes
// - upper nibble queued, lower byte commits both
// - 0x8F to burst control enables 15-byte bursts
// - non-volatile store only copied on command
// - temperature bits 11:6 index, 5:0 interpolate
// - slope direction bit reverses increment sign
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module tlc_core
    import tlc_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      pce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [11:0]               temp_sample,
    input  wire logic                      temp_sample_valid,
    input  wire logic                      rail_span_below_ground,
    input  wire logic [NUM_CH-1:0]         output_switch_enable_pin,
    output tlc_switch_type [NUM_CH-1:0]    switched_output,
    output logic [NUM_CH-1:0][CODE_W-1:0]  dac_code,
    output logic                           burst_enable,
    output logic [3:0]                     burst_length,
    output logic                           nv_store_request
);
    logic [INC_W-1:0]  inc_mem [NUM_CH][INC_COUNT];
    logic [CODE_W-1:0] base_code [NUM_CH];
    logic              slope_dir [NUM_CH];
    logic [CODE_W-1:0] forced_code [NUM_CH];
    logic [CODE_W-1:0] lut_code [NUM_CH];
    logic [7:0]        lut_shadow [NUM_CH];
    logic [NUM_CH-1:0] forced_code_select;
    logic              forced_temp_select;
    logic [11:0]       forced_temp;
    logic [7:0]        burst_length_control;
    logic              stage_valid;
    tlc_reg_type       stage_kind;
    logic              stage_ch;
    logic [4:0]        stage_bits;
    tlc_sw_state_type  sw_state [NUM_CH];
    logic [2:0]        sw_cnt [NUM_CH];
    tlc_engine_type    eng_state;
    logic              eng_ch;
    logic [11:0]       eng_temp;
    logic [11:0]       last_sample;
    logic              pending;
    logic              eng_up;
    logic [5:0]        eng_total;
    logic [5:0]        eng_step;
    logic [5:0]        eng_rem;
    logic [9:0]        eng_acc;

    tlc_reg_type       dec_kind;
    logic              dec_ch;
    logic [5:0]        dec_idx;
    logic [31:0]       next_prdata;
    logic              access;
    logic              write_done;
    logic              read_done;
    logic              stage_hit;
    logic [7:0]        wbyte;

    assign access     = pce && psel && penable;
    assign write_done = access && pready && pwrite && pstrb[0];
    assign read_done  = access && pready && !pwrite;
    assign wbyte      = pwdata[7:0];
    assign burst_enable = burst_length_control[BURST_EN_BIT];
    assign burst_length = burst_length_control[3:0];

    // the non-volatile store has no address here: it only sees copy requests
    always_comb begin
        dec_kind = R_NONE;
        dec_ch   = paddr[8];
        dec_idx  = paddr[7:2];
        if (paddr[1:0] != 2'h0) begin
            dec_kind = R_NONE;
        end else if (paddr[11:9] == 3'h0) begin
            if (paddr[7:0] < INC_END_OFF) begin
                dec_kind = R_INC;
            end else if (paddr[7:0] == BASE_HI_OFF) begin
                dec_kind = R_BASE_H;
            end else if (paddr[7:0] == BASE_LO_OFF) begin
                dec_kind = R_BASE_L;
            end else if (paddr[7:0] == FCODE_HI_OFF) begin
                dec_kind = R_FC_H;
            end else if (paddr[7:0] == FCODE_LO_OFF) begin
                dec_kind = R_FC_L;
            end else if (paddr[7:0] == LUT_HI_OFF) begin
                dec_kind = R_LUT_H;
            end else if (paddr[7:0] == LUT_LO_OFF) begin
                dec_kind = R_LUT_L;
            end
        end else if (paddr == CTRL_ADDR) begin
            dec_kind = R_CTRL;
        end else if (paddr == FTEMP_HI_ADDR) begin
            dec_kind = R_FT_H;
        end else if (paddr == FTEMP_LO_ADDR) begin
            dec_kind = R_FT_L;
        end else if (paddr == BURST_ADDR) begin
            dec_kind = R_BURST;
        end else if (paddr == STATUS_ADDR) begin
            dec_kind = R_STATUS;
        end else if (paddr == NV_CMD_ADDR) begin
            dec_kind = R_NV;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (dec_kind)
            R_INC:    next_prdata[INC_W-1:0] = inc_mem[dec_ch][dec_idx];
            R_BASE_H: next_prdata[4:0] = {slope_dir[dec_ch], base_code[dec_ch][11:8]};
            R_BASE_L: next_prdata[7:0] = base_code[dec_ch][7:0];
            R_FC_H:   next_prdata[3:0] = forced_code[dec_ch][11:8];
            R_FC_L:   next_prdata[7:0] = forced_code[dec_ch][7:0];
            R_LUT_H:  next_prdata[3:0] = lut_code[dec_ch][11:8];
            R_LUT_L:  next_prdata[7:0] = lut_shadow[dec_ch];
            R_CTRL:   next_prdata[2:0] = {forced_temp_select, forced_code_select};
            R_FT_H:   next_prdata[3:0] = forced_temp[11:8];
            R_FT_L:   next_prdata[7:0] = forced_temp[7:0];
            R_BURST:  next_prdata[7:0] = burst_length_control;
            R_STATUS: begin
                next_prdata[STAT_GAN_BIT]  = rail_span_below_ground;
                next_prdata[STAT_BUSY_BIT] = (eng_state != EN_IDLE);
            end
            default:  next_prdata = 32'h0000_0000;
        endcase
    end

    // one wait state: with pce high the answer comes in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (pce) begin
            pready  <= access && !pready;
            pslverr <= access && !pready && (dec_kind == R_NONE);
            if (access && !pready) begin
                prdata <= next_prdata;
            end
        end
    end

    always_comb begin
        stage_hit = 1'b0;
        if (stage_valid && stage_ch == dec_ch) begin
            stage_hit = (dec_kind == R_BASE_L && stage_kind == R_BASE_H)
                     || (dec_kind == R_FC_L && stage_kind == R_FC_H)
                     || (dec_kind == R_FT_L && stage_kind == R_FT_H);
        end
    end

    // upper nibble waits here so a 12-bit value never shows half old, half new
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_valid <= 1'b0;
            stage_kind  <= R_NONE;
            stage_ch    <= 1'b0;
            stage_bits  <= 5'h00;
        end else if (write_done) begin
            if (dec_kind == R_BASE_H || dec_kind == R_FC_H || dec_kind == R_FT_H) begin
                stage_valid <= 1'b1;
                stage_kind  <= dec_kind;
                stage_ch    <= dec_ch;
                stage_bits  <= wbyte[4:0];
            end else if (dec_kind == R_BASE_L || dec_kind == R_FC_L
                         || dec_kind == R_FT_L) begin
                stage_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                base_code[c]   <= BASE_RST;
                slope_dir[c]   <= 1'b0;
                forced_code[c] <= FCODE_RST;
                lut_shadow[c]  <= 8'h00;
                for (int i = 0; i < INC_COUNT; i++) begin
                    inc_mem[c][i] <= 4'h0;
                end
            end
        end else if (write_done) begin
            if (dec_kind == R_INC) begin
                inc_mem[dec_ch][dec_idx] <= wbyte[INC_W-1:0];
            end else if (dec_kind == R_BASE_L) begin
                base_code[dec_ch][7:0] <= wbyte;
                if (stage_hit) begin
                    base_code[dec_ch][11:8] <= stage_bits[3:0];
                    slope_dir[dec_ch]       <= stage_bits[POL_BIT];
                end
            end else if (dec_kind == R_FC_L) begin
                forced_code[dec_ch][7:0] <= wbyte;
                if (stage_hit) begin
                    forced_code[dec_ch][11:8] <= stage_bits[3:0];
                end
            end
        end else if (read_done && dec_kind == R_LUT_H) begin
            lut_shadow[dec_ch] <= lut_code[dec_ch][7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            forced_code_select   <= '0;
            forced_temp_select   <= 1'b0;
            forced_temp          <= FTEMP_RST;
            burst_length_control <= BURST_RST;
            nv_store_request     <= 1'b0;
        end else if (pce) begin
            nv_store_request <= write_done && dec_kind == R_NV && wbyte == NV_STORE_CMD;
            if (write_done && dec_kind == R_CTRL) begin
                forced_code_select <= wbyte[NUM_CH-1:0];
                forced_temp_select <= wbyte[FTEMP_SEL_BIT];
            end
            if (write_done && dec_kind == R_BURST) begin
                burst_length_control <= wbyte;
            end
            if (write_done && dec_kind == R_FT_L) begin
                forced_temp[7:0] <= wbyte;
                if (stage_hit) begin
                    forced_temp[11:8] <= stage_bits[3:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= '0;
        end else if (pce) begin
            for (int c = 0; c < NUM_CH; c++) begin
                // forced path bypasses the table span limit
                dac_code[c] <= forced_code_select[c] ? forced_code[c] : lut_code[c];
            end
        end
    end

    // one engine walks both channels in turn; area traded for a few cycles
    logic signed [11:0] set_t;
    logic signed [5:0]  set_k;
    logic [5:0]         sel_step;
    logic [5:0]         sel_index;
    logic [INC_W-1:0]   cur_inc;
    logic [15:0]        part_mag64;
    logic [9:0]         part_mag;
    logic signed [13:0] part_sum;
    logic [11:0]        part_code;
    logic               add_dir;

    always_comb begin
        set_t = $signed(eng_temp);
        if (set_t < EXTRAP_FLOOR) begin
            set_t = EXTRAP_FLOOR;
        end
        set_k = set_t[11:6];
        sel_step = (eng_state == EN_PART && eng_up) ? 6'(eng_total + 6'h01)
                 : (eng_state == EN_PART) ? eng_total : eng_step;
        if (eng_up) begin
            sel_index = HIGH_FIRST + sel_step;
        end else if (sel_step >= LOW_DEPTH) begin
            sel_index = 6'h00;
        end else begin
            sel_index = LOW_DEPTH - sel_step;
        end
        cur_inc = inc_mem[eng_ch][sel_index];
        if (eng_up) begin
            part_mag64 = {eng_acc, 6'h00} + 16'(eng_rem) * 16'(cur_inc);
        end else begin
            part_mag64 = {eng_acc, 6'h00} - 16'(eng_rem) * 16'(cur_inc);
        end
        part_mag = part_mag64[15:6];
        add_dir  = eng_up ^ slope_dir[eng_ch];
        part_sum = add_dir ? $signed({2'b00, base_code[eng_ch]}) + $signed({4'h0, part_mag})
                           : $signed({2'b00, base_code[eng_ch]}) - $signed({4'h0, part_mag});
        if (part_sum < 0) begin
            part_code = 12'h000;
        end else if (part_sum > $signed({2'b00, CODE_MAX})) begin
            part_code = CODE_MAX;
        end else begin
            part_code = part_sum[11:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_sample <= 12'h000;
            pending     <= 1'b0;
        end else if (pce) begin
            if (temp_sample_valid) begin
                last_sample <= temp_sample;
            end
            // a new sample in the start cycle survives: set wins
            pending <= temp_sample_valid || (write_done && dec_kind == R_FT_L)
                    || (pending && eng_state != EN_IDLE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_state <= EN_IDLE;
            eng_ch    <= 1'b0;
            eng_temp  <= 12'h000;
            eng_up    <= 1'b0;
            eng_total <= 6'h00;
            eng_step  <= 6'h00;
            eng_rem   <= 6'h00;
            eng_acc   <= 10'h000;
            for (int c = 0; c < NUM_CH; c++) begin
                lut_code[c] <= 12'h000;
            end
        end else if (pce) begin
            case (eng_state)
                EN_IDLE: begin
                    if (pending) begin
                        eng_temp  <= forced_temp_select ? forced_temp : last_sample;
                        eng_ch    <= 1'b0;
                        eng_state <= EN_SETUP;
                    end
                end
                EN_SETUP: begin
                    eng_up    <= (set_k >= BASELINE_STEP);
                    eng_total <= (set_k >= BASELINE_STEP) ? 6'(set_k - BASELINE_STEP)
                                                          : 6'(BASELINE_STEP - set_k);
                    eng_rem   <= set_t[5:0];
                    eng_step  <= 6'h01;
                    eng_acc   <= 10'h000;
                    eng_state <= EN_SUM;
                end
                EN_SUM: begin
                    if (eng_step > eng_total) begin
                        eng_state <= EN_PART;
                    end else begin
                        eng_acc  <= eng_acc + {6'h00, cur_inc};
                        eng_step <= eng_step + 6'h01;
                    end
                end
                EN_PART: begin
                    lut_code[eng_ch] <= part_code;
                    if (eng_ch == 1'b0) begin
                        eng_ch    <= 1'b1;
                        eng_state <= EN_SETUP;
                    end else begin
                        eng_state <= EN_IDLE;
                    end
                end
                default: eng_state <= EN_IDLE;
            endcase
        end
    end

    // pin drives the switch; bus traffic never reaches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                sw_state[c]        <= SW_RAIL;
                sw_cnt[c]          <= 3'h0;
                switched_output[c] <= '{buf_closed: 1'b0, rail_closed: 1'b1};
            end
        end else if (pce) begin
            for (int c = 0; c < NUM_CH; c++) begin
                case (sw_state[c])
                    SW_RAIL, SW_BUF: begin
                        if (output_switch_enable_pin[c] != (sw_state[c] == SW_BUF)) begin
                            sw_state[c]        <= SW_GAP;
                            sw_cnt[c]          <= DEAD_CNT_INIT;
                            switched_output[c] <= '{buf_closed: 1'b0, rail_closed: 1'b0};
                        end
                    end
                    SW_GAP: begin
                        if (sw_cnt[c] != 3'h0) begin
                            sw_cnt[c] <= sw_cnt[c] - 3'h1;
                        end else if (output_switch_enable_pin[c]) begin
                            sw_state[c]        <= SW_BUF;
                            switched_output[c] <= '{buf_closed: 1'b1, rail_closed: 1'b0};
                        end else begin
                            sw_state[c]        <= SW_RAIL;
                            switched_output[c] <= '{buf_closed: 1'b0, rail_closed: 1'b1};
                        end
                    end
                    default: sw_state[c] <= SW_RAIL;
                endcase
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_no_short: assert property (
        !(switched_output[0].buf_closed && switched_output[0].rail_closed))
        else $error("buffer and rail switch closed together");
    chk_gap_before_buf: assert property (
        $rose(switched_output[1].buf_closed) |->
            $past(switched_output[1] == 2'b00, 1) && $past(switched_output[1] == 2'b00, 2))
        else $error("buffer switch closed without open gap");
    chk_pin_high_buf: assert property (
        (pce && output_switch_enable_pin[0])[*4] |-> switched_output[0].buf_closed)
        else $error("output did not follow high enable pin");
    chk_pin_low_rail: assert property (
        (pce && !output_switch_enable_pin[0])[*4] |-> switched_output[0].rail_closed)
        else $error("output did not rest on negative rail");
    chk_nibble_queued: assert property (
        write_done && dec_kind == R_FC_H |=> forced_code[0] == $past(forced_code[0])
            && forced_code[1] == $past(forced_code[1]))
        else $error("upper nibble write changed the forced code");
    chk_pair_commit: assert property (
        write_done && dec_kind == R_FC_L && stage_hit |=>
            forced_code[$past(dec_ch)] == {$past(stage_bits[3:0]), $past(wbyte)})
        else $error("lower byte write did not commit both halves");
    chk_burst_enable: assert property (
        write_done && dec_kind == R_BURST && wbyte == BURST_FULL |=>
            burst_enable && burst_length == 4'hF)
        else $error("burst control write not applied at once");
    chk_code_select: assert property (
        pce && forced_code_select[0] |=> dac_code[0] == $past(forced_code[0]))
        else $error("converter code not taken from forced code");
    chk_span_limit: assert property (
        eng_state == EN_PART |-> part_mag <= MAX_SPAN)
        else $error("table excursion beyond span limit");
    chk_answer_time: assert property (
        access && !pready |=> pready || !pce)
        else $error("bus answer not given in second access cycle");
endmodule : tlc_core

// >>> hdl/tlc_pkg.sv
// constants and types of the temperature lookup code path
// assumes a 100 MHz APB clock; one file of logic imports it
package tlc_pkg;
    localparam int NUM_CH    = 2;
    localparam int INC_COUNT = 39;
    localparam int INC_W     = 4;
    localparam int CODE_W    = 12;
    localparam int CLK_MHZ      = 100;
    localparam int DEAD_TIME_NS = 20;
    localparam int DEAD_RAW     = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int DEAD_CYC     = (DEAD_RAW < 1) ? 1 : DEAD_RAW;
    localparam logic [2:0] DEAD_CNT_INIT = 3'(DEAD_CYC - 1);
    // per channel block, channel stride 0x100
    localparam logic [7:0]  INC_END_OFF   = 8'h9C;
    localparam logic [7:0]  BASE_HI_OFF   = 8'hA0;
    localparam logic [7:0]  BASE_LO_OFF   = 8'hA4;
    localparam logic [7:0]  FCODE_HI_OFF  = 8'hA8;
    localparam logic [7:0]  FCODE_LO_OFF  = 8'hAC;
    localparam logic [7:0]  LUT_HI_OFF    = 8'hB0;
    localparam logic [7:0]  LUT_LO_OFF    = 8'hB4;
    localparam logic [11:0] CTRL_ADDR     = 12'h200;
    localparam logic [11:0] FTEMP_HI_ADDR = 12'h204;
    localparam logic [11:0] FTEMP_LO_ADDR = 12'h208;
    localparam logic [11:0] BURST_ADDR    = 12'h20C;
    localparam logic [11:0] STATUS_ADDR   = 12'h210;
    localparam logic [11:0] NV_CMD_ADDR   = 12'h214;
    localparam int POL_BIT       = 4;
    localparam int FTEMP_SEL_BIT = 2;
    localparam int BURST_EN_BIT  = 7;
    localparam int STAT_GAN_BIT  = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam logic [11:0] BASE_RST   = 12'h000;
    localparam logic [11:0] FCODE_RST  = 12'h000;
    localparam logic [11:0] FTEMP_RST  = 12'h000;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  BURST_RST  = 8'h00;
    localparam logic [7:0]  BURST_FULL = 8'h8F;
    localparam logic [7:0]  NV_STORE_CMD = 8'hA5;
    localparam logic signed [5:0]  BASELINE_STEP = 6'sh06;
    localparam logic signed [11:0] EXTRAP_FLOOR  = 12'shD80;
    localparam logic [5:0]  LOW_DEPTH  = 6'h0D;
    localparam logic [5:0]  HIGH_FIRST = 6'h0C;
    localparam logic [9:0]  MAX_SPAN   = 10'h270;
    localparam logic [11:0] CODE_MAX   = 12'hFFF;

    typedef enum {SW_RAIL, SW_GAP, SW_BUF} tlc_sw_state_type;
    typedef enum {EN_IDLE, EN_SETUP, EN_SUM, EN_PART} tlc_engine_type;
    typedef enum logic [3:0] {
        R_NONE, R_INC, R_BASE_H, R_BASE_L, R_FC_H, R_FC_L, R_LUT_H, R_LUT_L,
        R_CTRL, R_FT_H, R_FT_L, R_BURST, R_STATUS, R_NV
    } tlc_reg_type;
    typedef struct packed {
        logic buf_closed;
        logic rail_closed;
    } tlc_switch_type;
endpackage : tlc_pkg

// >>> testbench/testbench.sv
// self-checking bench: APB master, sensor model, output pins
// assumes one pclk domain, registers answer with pready
`timescale 1ns/1ps
module testbench import tlc_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rail;
    logic        burst_enable, tv, nvs;
    logic [11:0] paddr, temp, x;
    logic [31:0] pwdata, prdata;
    logic [3:0]  burst_length, r;
    logic [1:0]  pins;
    tlc_switch_type [1:0]   sw;
    logic [1:0][11:0]       code;
    logic [32:0] q[$];
    int          mismatches, samples_checked, i;
    tlc_sensor_model sens (.pclk, .temp_sample(temp), .temp_sample_valid(tv));
    tlc_core u_dut (.pclk, .presetn, .pce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'h1), .prdata, .pready, .pslverr, .temp_sample(temp), .temp_sample_valid(tv),
        .rail_span_below_ground(rail), .output_switch_enable_pin(pins), .switched_output(sw),
        .dac_code(code), .burst_enable, .burst_length, .nv_store_request(nvs));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("mismatches %0d checks %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    // expected read result {pslverr, prdata} queued for the watcher
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        if (!w) q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n == 20) begin
            mismatches++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("rdata", q.size() ? q[0] : 33'h1FFFFFFFF, {pslverr, prdata});
            if (q.size() > 0) void'(q.pop_front());
        end
    end
    initial begin
        {psel, penable, pwrite, presetn, pins} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        r = 4'($urandom(96083)) | 4'h1;
        rail = 1'($urandom);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        chk("sw", 33'h5, 33'(sw));
        apb(1'b1, CTRL_ADDR, 8'h01, 33'h0);
        apb(1'b1, 12'h0A8, 8'h0F, 33'h0);
        settle(3);
        chk("queued", 33'h0, code[0]);
        apb(1'b1, 12'h0AC, 8'hFF, 33'h0);
        settle(3);
        chk("forced", 33'hFFF, code[0]);
        apb(1'b1, 12'h134, {4'h0, r}, 33'h0);
        for (i = 0; i < 2; i++) begin
            x = (i == 1) ? 12'h100 - r : 12'h100 + r;
            apb(1'b1, 12'h1A0, {3'b000, i[0], 4'h1}, 33'h0);
            apb(1'b1, 12'h1A4, 8'h00, 33'h0);
            sens.send(12'h1C0);
            settle(70); // one start cycle, then two channels at most 28 cycles each
            chk("lut", x, code[1]);
            apb(1'b0, 12'h1B0, 8'h00, 33'(x[11:8]));
            apb(1'b0, 12'h1B4, 8'h00, 33'(x[7:0]));
        end
        apb(1'b1, CTRL_ADDR, 8'h05, 33'h0);
        apb(1'b1, FTEMP_HI_ADDR, 8'h01, 33'h0);
        apb(1'b1, FTEMP_LO_ADDR, 8'h80, 33'h0);
        settle(20);
        chk("ftemp", 33'h100, code[1]);
        apb(1'b1, BURST_ADDR, BURST_FULL, 33'h0);
        settle(1);
        chk("burst", 33'h1F, {burst_enable, burst_length});
        apb(1'b1, NV_CMD_ADDR, NV_STORE_CMD, 33'h0);
        settle(0);
        chk("nv", 33'h1, 33'(nvs));
        settle(1);
        chk("nv_end", 33'h0, 33'(nvs));
        @(posedge pclk);
        pins <= 2'b11;
        settle(1);
        chk("gap", 33'h0, 33'(sw));
        settle(3);
        chk("buf", 33'hA, 33'(sw));
        @(posedge pclk);
        pins <= 2'b00;
        settle(4);
        chk("rail", 33'h5, 33'(sw));
        apb(1'b0, 12'h3F0, 8'h00, 33'h100000000);
        apb(1'b0, STATUS_ADDR, 8'h00, {32'h0, rail});
        settle(4);
        finish_test();
    end
endmodule : testbench

// >>> testbench/tlc_sensor_model.sv
// sensor stand-in: one temperature word per one-cycle strobe
// assumes callers run in the pclk domain
`timescale 1ns/1ps
module tlc_sensor_model (
    input  wire logic   pclk,
    output logic [11:0] temp_sample,
    output logic        temp_sample_valid
);
    initial begin
        temp_sample = 12'h000;
        temp_sample_valid = 1'b0;
    end
    task automatic send(input logic [11:0] t);
        @(posedge pclk);
        temp_sample <= t;
        temp_sample_valid <= 1'b1;
        @(posedge pclk);
        temp_sample_valid <= 1'b0;
        temp_sample <= ~t; // word not held past its strobe
    endtask : send
endmodule : tlc_sensor_model
